// file: cis_regs.vh
// constants for the counter input synchronizer
`ifndef CIS_REGS_VH
`define CIS_REGS_VH
// ***************************************
// register offsets
// ***************************************
`define CIS_REG_CTRL       4'h0
`define CIS_REG_COUNT      4'h1
`define CIS_REG_BUF        4'h2
`define CIS_REG_STATUS     4'h3
`define CIS_REG_LOAD       4'h4
// ***************************************
// control fields
// ***************************************
`define CIS_CTRL_EN_BIT    0
`define CIS_CTRL_DIR_BIT   1
`define CIS_CTRL_DUP_BIT   2
`define CIS_CTRL_POS_BIT   3
`define CIS_CTRL_SRC_LSB   4
`define CIS_CTRL_SRC_MSB   6
`define CIS_CTRL_RESET     32'h00000000
// ***************************************
// source selection codes
// ***************************************
`define CIS_SRC_TB80       3'h0
`define CIS_SRC_TB20       3'h1
`define CIS_SRC_TB100K     3'h2
`define CIS_SRC_PXICLK     3'h3
`define CIS_SRC_EXT        3'h4
// ***************************************
// synchronization modes
// ***************************************
`define CIS_MODE_80        2'h0
`define CIS_MODE_INT       2'h1
`define CIS_MODE_EXT       2'h2
// ***************************************
// timing: core clock 50 MHz stands for the timebase domain
// ***************************************
`define CIS_CLK_MHZ        50
`define CIS_SRC_MAX_MHZ    20
`define CIS_SRC_MIN_CYC    ((`CIS_CLK_MHZ + `CIS_SRC_MAX_MHZ - 1) / `CIS_SRC_MAX_MHZ)
`define CIS_DELAY_STAGES   2
`endif

// file: cis_core.v
// counter input synchronizer with duplicate count prevention
`timescale 1ns/1ps
`include "cis_regs.vh"

module cis_core (
   input  wire        core_clk_i,
   input  wire        rstn_i,
   input  wire        ce_i,
   input  wire [3:0]  addr_i,
   input  wire [31:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [31:0] rdata_o,
   input  wire        src_ext_i,
   input  wire        src_int_i,
   input  wire        gate_i,
   output reg  [31:0] buf_data_o,
   output reg         buf_wr_o,
   output reg  [1:0]  mode_o
);

   // ***************************************
   // control register
   // ***************************************
   reg  [31:0] ctrl;
   reg  [31:0] count;
   reg  [31:0] load_val;
   reg         overrun;
   wire        enable   = ctrl[`CIS_CTRL_EN_BIT];
   wire        down     = ctrl[`CIS_CTRL_DIR_BIT];
   wire        dup_prev = ctrl[`CIS_CTRL_DUP_BIT];
   wire        pos_meas = ctrl[`CIS_CTRL_POS_BIT];
   wire [2:0]  src_sel  = ctrl[`CIS_CTRL_SRC_MSB:`CIS_CTRL_SRC_LSB];

   // ***************************************
   // mode selection
   // ***************************************
   reg [1:0] next_mode;
   always @* begin
      if (dup_prev || pos_meas) begin
         next_mode = `CIS_MODE_80;
      end else begin
         case (src_sel)
            `CIS_SRC_TB80:   next_mode = `CIS_MODE_80;
            `CIS_SRC_TB20,
            `CIS_SRC_TB100K,
            `CIS_SRC_PXICLK: next_mode = `CIS_MODE_INT;
            default:         next_mode = `CIS_MODE_EXT;
         endcase
      end
   end

   // source of the selected kind; internal timebases arrive already divided
   wire src_raw = (src_sel >= `CIS_SRC_EXT) ? src_ext_i : src_int_i;

   // ***************************************
   // input synchronizers
   // ***************************************
   // three flops per input, two sync stages and prev; only the second stage and prev feed any logic
   // bit 0 carries the source, bit 1 the gate
   wire [1:0] sync_in;
   wire [1:0] sync_out;
   wire [1:0] sync_prev;
   assign sync_in = {gate_i, src_raw};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
         reg [1:0] meta;
         reg       prev;
         always @(posedge core_clk_i) begin
            if (!rstn_i) begin
               meta <= 2'h0;
               prev <= 1'b0;
            end else if (ce_i) begin
               meta <= {meta[0], sync_in[gi]};
               prev <= meta[1];
            end
         end
         assign sync_out[gi]  = meta[1];
         assign sync_prev[gi] = prev;
      end
   endgenerate

   wire       src_s  = sync_out[0];
   wire       gate_s = sync_out[1];
   wire       src_q  = sync_prev[0];
   wire       gate_q = sync_prev[1];

   // ***************************************
   // delayed source copy
   // ***************************************
   // a short register chain stands in for the few nanoseconds of delay
   reg [`CIS_DELAY_STAGES-1:0] src_dly;
   wire       src_d = src_dly[`CIS_DELAY_STAGES-1];
   reg        src_dq;

   always @(posedge core_clk_i) begin
      if (!rstn_i) begin
         src_dly <= {`CIS_DELAY_STAGES{1'b0}};
         src_dq  <= 1'b0;
      end else if (ce_i) begin
         src_dly <= {src_dly[`CIS_DELAY_STAGES-2:0], src_s};
         src_dq  <= src_d;
      end
   end

   // ***************************************
   // edge detection
   // ***************************************
   wire src_rise  = src_s & ~src_q;
   wire src_fall  = ~src_s & src_q;
   wire gate_rise = gate_s & ~gate_q;
   wire dsrc_rise = src_d & ~src_dq;

   // gate level captured on the mode's capture edge of the source
   reg  gate_cap;
   reg  pend;
   wire cap_edge = (mode_o == `CIS_MODE_80)  ? src_rise :
                   (mode_o == `CIS_MODE_INT) ? src_fall :
                   dsrc_rise;
   wire tb_mode  = dup_prev;

   // a gate edge seen by the source-sampled path: one cycle, on the capture edge only,
   // so a cleared pending store cannot re-arm from a stale captured level
   wire src_gate_rise = cap_edge & gate_s & ~gate_cap;

   // ***************************************
   // counter and buffer
   // ***************************************
   wire [31:0] step_val = down ? (count - 32'h00000001) : (count + 32'h00000001);
   reg  [31:0] next_count;
   reg         store;
   reg  [31:0] store_val;

   always @* begin
      next_count = count;
      store      = 1'b0;
      store_val  = count;
      if (tb_mode) begin
         // one count per source rise regardless of pulse length
         if (src_rise)
            next_count = step_val;
         if (gate_rise) begin
            store      = 1'b1;
            store_val  = src_rise ? step_val : count;
            next_count = 32'h00000000;
         end
      end else if (src_rise) begin
         // counting only on source rise, so a quiet source stores nothing
         if (pend) begin
            store      = 1'b1;
            store_val  = count;
            next_count = down ? 32'hffffffff : 32'h00000001;
         end else begin
            next_count = step_val;
         end
      end
   end

   // ***************************************
   // software writes
   // ***************************************
   always @(posedge core_clk_i) begin
      if (!rstn_i) begin
         ctrl     <= `CIS_CTRL_RESET;
         load_val <= 32'h00000000;
      end else if (ce_i && wr_i) begin
         case (addr_i)
            `CIS_REG_CTRL: begin
               ctrl <= wdata_i;
            end
            `CIS_REG_LOAD: begin
               load_val <= wdata_i;
            end
            default: begin
            end
         endcase
      end
   end

   // ***************************************
   // mode register
   // ***************************************
   always @(posedge core_clk_i) begin
      if (!rstn_i) begin
         mode_o <= `CIS_MODE_80;
      end else if (ce_i) begin
         mode_o <= next_mode;
      end
   end

   // ***************************************
   // gate capture
   // ***************************************
   always @(posedge core_clk_i) begin
      if (!rstn_i) begin
         gate_cap <= 1'b0;
      end else if (ce_i && cap_edge) begin
         gate_cap <= gate_s;
      end
   end

   // ***************************************
   // count register
   // ***************************************
   // a software write of the count wins over a step in the same cycle
   wire count_wr = wr_i && (addr_i == `CIS_REG_COUNT);

   always @(posedge core_clk_i) begin
      if (!rstn_i) begin
         count <= 32'h00000000;
      end else if (ce_i) begin
         if (count_wr) begin
            count <= wdata_i;
         end else if (enable) begin
            count <= next_count;
         end
      end
   end

   // ***************************************
   // buffer output
   // ***************************************
   always @(posedge core_clk_i) begin
      if (!rstn_i) begin
         buf_data_o <= 32'h00000000;
         buf_wr_o   <= 1'b0;
      end else if (ce_i) begin
         buf_wr_o <= enable & store;
         if (enable && store) begin
            buf_data_o <= store_val;
         end
      end
   end

   // ***************************************
   // pending store
   // ***************************************
   // pending store waits for a source rise; a second gate edge meanwhile is lost
   wire pend_clr = !tb_mode && src_rise && pend;
   wire pend_set = !tb_mode && src_gate_rise;

   always @(posedge core_clk_i) begin
      if (!rstn_i) begin
         pend <= 1'b0;
      end else if (ce_i) begin
         if (!enable) begin
            pend <= 1'b0;
         end else if (pend_clr) begin
            pend <= 1'b0;
         end else if (pend_set) begin
            pend <= 1'b1;
         end
      end
   end

   // ***************************************
   // overrun flag
   // ***************************************
   // a lost gate edge and a software clear in one cycle: the set wins
   wire overrun_evt = enable && pend_set && pend;
   wire overrun_clr = wr_i && (addr_i == `CIS_REG_STATUS) && wdata_i[0];

   always @(posedge core_clk_i) begin
      if (!rstn_i) begin
         overrun <= 1'b0;
      end else if (ce_i) begin
         if (overrun_evt) begin
            overrun <= 1'b1;
         end else if (overrun_clr) begin
            overrun <= 1'b0;
         end
      end
   end

   // ***************************************
   // read back
   // ***************************************
   wire [31:0] status_word = {27'h0000000, mode_o, pend, enable, overrun};

   always @(posedge core_clk_i) begin
      if (!rstn_i) begin
         rdata_o <= 32'h00000000;
      end else if (ce_i) begin
         if (rd_i) begin
            case (addr_i)
               `CIS_REG_CTRL: begin
                  rdata_o <= ctrl;
               end
               `CIS_REG_COUNT: begin
                  rdata_o <= count;
               end
               `CIS_REG_BUF: begin
                  rdata_o <= buf_data_o;
               end
               `CIS_REG_STATUS: begin
                  rdata_o <= status_word;
               end
               `CIS_REG_LOAD: begin
                  rdata_o <= load_val;
               end
               default: begin
                  rdata_o <= 32'h00000000;
               end
            endcase
         end else begin
            rdata_o <= 32'h00000000;
         end
      end
   end

endmodule

// file: cis_core_properties.sv
// port assertions for the input synchronizer
`timescale 1ns/1ps
`include "cis_regs.vh"
module cis_core_properties (
   input wire        core_clk_i,
   input wire        rstn_i,
   input wire        ce_i,
   input wire [3:0]  addr_i,
   input wire [31:0] wdata_i,
   input wire        wr_i,
   input wire        gate_i,
   input wire [31:0] buf_data_o,
   input wire        buf_wr_o,
   input wire [1:0]  mode_o
);
   wire       cw = wr_i && ce_i && addr_i == `CIS_REG_CTRL;
   wire [4:0] f  = wdata_i[6:2];
   wire       dp = cw && f[1:0] != 2'h0;
   wire       np = cw && f[1:0] == 2'h0;
   reg        dup;
   // shadow of an enabled prevention setting, so gate checks apply only there
   always @(posedge core_clk_i) dup <= rstn_i && (cw ? f[0] && wdata_i[0] : dup);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   chk_mode_prev: assert property (dp |-> ##[1:2] mode_o == 2'h0)
      else $error("mode");
   chk_mode_tb80: assert property (np && f[4:2] == 3'h0 |-> ##[1:2] mode_o == 2'h0)
      else $error("mode");
   chk_mode_int: assert property (np && !f[4] && f[3:2] != 2'h0 |-> ##[1:2] mode_o == 2'h1)
      else $error("mode");
   chk_mode_ext: assert property (np && f[4] |-> ##[1:2] mode_o == 2'h2)
      else $error("mode");
   chk_mode_legal: assert property (mode_o != 2'h3) else $error("mode code");
   chk_store_single: assert property (buf_wr_o |=> !buf_wr_o) else $error("pulse");
   chk_buf_hold: assert property ($changed(buf_data_o) && !$past(buf_wr_o) |-> ##[0:1] buf_wr_o)
      else $error("hold");
   chk_gate_store: assert property (dup && $rose(gate_i) |-> ##[2:6] buf_wr_o)
      else $error("store");
   cover property (buf_wr_o && dup);
   cover property (buf_wr_o && mode_o == 2'h2);
   cover property (np && f[4:2] == 3'h3);
endmodule
bind cis_core cis_core_properties chk (.*);

// file: cis_src_gen.sv
// source and gate generator driving the synchronizer inputs
`timescale 1ns/1ps
`include "cis_regs.vh"
module cis_src_gen (
   input  wire clk_i,
   output reg  src_o = 1'b0,
   output reg  gate_o = 1'b0
);
   // high and low never shorter than the 20 mhz ceiling allows
   task pulse(input integer hi);
      src_o <= 1'b1;
      repeat (hi + `CIS_SRC_MIN_CYC) @(posedge clk_i);
      src_o <= 1'b0;
      repeat (`CIS_SRC_MIN_CYC) @(posedge clk_i);
   endtask
   // long enough for the two-flop synchronizer to see the level
   task gate(input lvl);
      gate_o <= lvl;
      repeat (6) @(posedge clk_i);
   endtask
endmodule

// file: test_counter_input_synchronizer.sv
// self-checking bench for the input synchronizer
`timescale 1ns/1ps
`include "cis_regs.vh"
module test_counter_input_synchronizer;
   localparam [127:0] rows = 128'h0045_0029_0001_0111_0121_0131_0241_0271;
   reg         core_clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, ce_i = 1'b1;
   reg  [3:0]  addr_i = 4'h0;
   reg  [31:0] wdata_i = 32'h0;
   wire [31:0] rdata_o, buf_data_o;
   wire        buf_wr_o, src, gate;
   wire [1:0]  mode_o;
   integer     mismatches = 0, checks_done = 0, stores = 0, k, s;
   cis_src_gen gen (.clk_i(core_clk_i), .src_o(src), .gate_o(gate));
   cis_core dut (.*, .ce_i(ce_i), .src_ext_i(src), .src_int_i(src), .gate_i(gate));
   always #10 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) if (buf_wr_o === 1'b1) stores <= stores + 1;
   task check(input [63:0] what, input [31:0] seen, input [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("[ERR] %0s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task rd(input [3:0] a, input [31:0] exp);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1 check("rdata", rdata_o, exp);
      @(posedge core_clk_i);
   endtask
   task meas(input [31:0] exp);
      s = stores;
      gen.gate(1'b1);
      gen.gate(1'b0);
      check("stores", stores - s, 32'h1);
      check("buf", buf_data_o, exp);
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      @(posedge core_clk_i);
      rd(`CIS_REG_CTRL, `CIS_CTRL_RESET);
      rd(4'hf, 32'h0);
      $display("bus test done");
      for (k = 0; k < 8; k = k + 1) begin
         wr(`CIS_REG_CTRL, {25'h0, rows[16*k +: 7]});
         @(posedge core_clk_i);
         #1 check("mode", {30'h0, mode_o}, {30'h0, rows[16*k+8 +: 2]});
      end
      $display("mode test done");
      wr(`CIS_REG_CTRL, 32'h45);
      wr(`CIS_REG_COUNT, 32'h7);
      meas(32'h7);
      repeat (2) gen.pulse(8);
      meas(32'h2);
      wr(`CIS_REG_CTRL, 32'h47);
      repeat (2) gen.pulse(0);
      meas(32'hffff_fffe);
      $display("prevention test done");
      wr(`CIS_REG_CTRL, 32'h41);
      s = stores;
      gen.gate(1'b1);
      check("stores", stores - s, 32'h0);
      repeat (2) gen.pulse(4);
      check("stores", stores - s, 32'h1);
      check("buf", buf_data_o, 32'h1);
      $display("external test done");
      ce_i <= 1'b0;
      gen.pulse(0);
      ce_i <= 1'b1;
      rd(`CIS_REG_COUNT, 32'h1);
      $display("freeze test done");
      summarize;
   end
endmodule
